// ---- gpm_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpm_pin_model (
   input wire logic clk_sys,
   input wire gpm_pkg::gpm_pad_t pad,
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   output logic [7:0] pin_level
);
   // ----------
   // Pin levels
   // ----------
   logic [7:0] last_r = 8'h00;

   always_ff @(posedge clk_sys) begin
      last_r <= pin_level;
   end

   // A floating pin shows the inverse of its last level, never a stale copy
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pad.oe_n[i] && !pad.analog[i]) begin
            pin_level[i] = pad.out[i];
         end else if (ext_en[i]) begin
            pin_level[i] = ext_val[i];
         end else if (pad.pullup_en[i] && !pad.analog[i]) begin
            pin_level[i] = 1'b1;
         end else begin
            pin_level[i] = ~last_r[i];
         end
      end
   end
endmodule : gpm_pin_model
`default_nettype wire

// ---- gpm_pkg.sv ----
package gpm_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_P0_DATA = 8'h80;
   localparam logic [7:0] ADDR_P0_OMODE = 8'hA4;
   localparam logic [7:0] ADDR_P0_SKIP = 8'hD4;
   localparam logic [7:0] ADDR_P1_MATCH = 8'hE1;
   localparam logic [7:0] ADDR_P1_MASK = 8'hE2;
   localparam logic [7:0] ADDR_P0_IMODE = 8'hF1;
   localparam logic [7:0] ADDR_P0_MATCH = 8'hF3;
   localparam logic [7:0] ADDR_P0_MASK = 8'hF4;
   localparam logic [3:0] PAGE_0 = 4'h0;
   localparam logic [3:0] PAGE_F = 4'hF;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_DATA = 8'hFF;
   localparam logic [7:0] RST_OMODE = 8'h00;
   localparam logic [7:0] RST_SKIP = 8'h00;
   localparam logic [7:0] RST_MATCH = 8'hFF;
   localparam logic [7:0] RST_MASK = 8'h00;
   localparam logic [7:0] RST_IMODE = 8'hFF;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic wr;
      logic rd;
      logic rmw;
      logic bit_op;
      logic [2:0] bit_idx;
      logic bit_val;
      logic [3:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gpm_sfr_req_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_n;
      logic [7:0] pullup_en;
      logic [7:0] analog;
   } gpm_pad_t;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic gpm_mismatch(input logic [7:0] pins,
                                         input logic [7:0] val,
                                         input logic [7:0] mask);
      gpm_mismatch = ((pins & mask) != (val & mask));
   endfunction : gpm_mismatch

   function automatic logic gpm_sel(input gpm_sfr_req_t req,
                                    input logic [7:0] addr,
                                    input logic any_page,
                                    input logic [3:0] page);
      gpm_sel = (req.addr == addr) && (any_page || (req.page == page));
   endfunction : gpm_sel

endpackage : gpm_pkg

// ---- gpm_port_io.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpm_port_io #(
   parameter int WIDTH = 8
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire gpm_pkg::gpm_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata_r,
   input wire logic [WIDTH-1:0] port0_pin_in,
   input wire logic [WIDTH-1:0] port1_pin_in,
   input wire logic [WIDTH-1:0] xbar_sel,
   input wire logic [WIDTH-1:0] xbar_dout,
   input wire logic [WIDTH-1:0] smbus_pins,
   output gpm_pkg::gpm_pad_t pad_r,
   output logic [WIDTH-1:0] port0_crossbar_skip_r,
   output logic port_mismatch_r,
   output logic port_wake_r
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [WIDTH-1:0] p0_meta_r;
   logic [WIDTH-1:0] p0_sync_r;
   logic [WIDTH-1:0] p1_meta_r;
   logic [WIDTH-1:0] p1_sync_r;
   logic [WIDTH-1:0] p0_meta_nxt;
   logic [WIDTH-1:0] p0_sync_nxt;
   logic [WIDTH-1:0] p1_meta_nxt;
   logic [WIDTH-1:0] p1_sync_nxt;

   always_comb begin
      p0_meta_nxt = port0_pin_in;
      p0_sync_nxt = p0_meta_r;
      p1_meta_nxt = port1_pin_in;
      p1_sync_nxt = p1_meta_r;
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         p0_meta_r <= '0;
         p0_sync_r <= '0;
         p1_meta_r <= '0;
         p1_sync_r <= '0;
      end else begin
         p0_meta_r <= p0_meta_nxt;
         p0_sync_r <= p0_sync_nxt;
         p1_meta_r <= p1_meta_nxt;
         p1_sync_r <= p1_sync_nxt;
      end
   end

   // ----------------------------------------
   // Configuration and data registers
   // ----------------------------------------
   logic [WIDTH-1:0] p0_latch_r;
   logic [WIDTH-1:0] p0_omode_r;
   logic [WIDTH-1:0] p0_imode_r;
   logic [WIDTH-1:0] p0_match_r;
   logic [WIDTH-1:0] p0_mask_r;
   logic [WIDTH-1:0] p1_match_r;
   logic [WIDTH-1:0] p1_mask_r;
   logic [WIDTH-1:0] p0_latch_nxt;
   logic [WIDTH-1:0] p0_omode_nxt;
   logic [WIDTH-1:0] p0_imode_nxt;
   logic [WIDTH-1:0] p0_skip_nxt;
   logic [WIDTH-1:0] p0_match_nxt;
   logic [WIDTH-1:0] p0_mask_nxt;
   logic [WIDTH-1:0] p1_match_nxt;
   logic [WIDTH-1:0] p1_mask_nxt;
   logic byte_wr;
   logic [WIDTH-1:0] p0_digital;

   // Analog pins have their receiver off and read low
   assign p0_digital = p0_sync_r & p0_imode_r;

   always_comb begin
      byte_wr = sfr_req.wr && !sfr_req.bit_op;
      p0_latch_nxt = p0_latch_r;
      p0_omode_nxt = p0_omode_r;
      p0_imode_nxt = p0_imode_r;
      p0_skip_nxt = port0_crossbar_skip_r;
      p0_match_nxt = p0_match_r;
      p0_mask_nxt = p0_mask_r;
      p1_match_nxt = p1_match_r;
      p1_mask_nxt = p1_mask_r;
      // Data latch on every page, byte or single bit
      if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_DATA, 1'b1, gpm_pkg::PAGE_0)) begin
         if (byte_wr) begin
            p0_latch_nxt = sfr_req.wdata;
         end else if (sfr_req.wr) begin
            p0_latch_nxt[sfr_req.bit_idx] = sfr_req.bit_val;
         end
      end
      if (byte_wr) begin
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_MATCH, 1'b0, gpm_pkg::PAGE_0)) begin
            p0_match_nxt = sfr_req.wdata;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_MASK, 1'b0, gpm_pkg::PAGE_0)) begin
            p0_mask_nxt = sfr_req.wdata;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P1_MATCH, 1'b0, gpm_pkg::PAGE_0)) begin
            p1_match_nxt = sfr_req.wdata;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P1_MASK, 1'b0, gpm_pkg::PAGE_0)) begin
            p1_mask_nxt = sfr_req.wdata;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_IMODE, 1'b0, gpm_pkg::PAGE_F)) begin
            p0_imode_nxt = sfr_req.wdata;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_OMODE, 1'b0, gpm_pkg::PAGE_F)) begin
            p0_omode_nxt = sfr_req.wdata;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_SKIP, 1'b0, gpm_pkg::PAGE_F)) begin
            p0_skip_nxt = sfr_req.wdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         p0_latch_r <= gpm_pkg::RST_DATA;
         p0_omode_r <= gpm_pkg::RST_OMODE;
         p0_imode_r <= gpm_pkg::RST_IMODE;
         port0_crossbar_skip_r <= gpm_pkg::RST_SKIP;
         p0_match_r <= gpm_pkg::RST_MATCH;
         p0_mask_r <= gpm_pkg::RST_MASK;
         p1_match_r <= gpm_pkg::RST_MATCH;
         p1_mask_r <= gpm_pkg::RST_MASK;
      end else begin
         p0_latch_r <= p0_latch_nxt;
         p0_omode_r <= p0_omode_nxt;
         p0_imode_r <= p0_imode_nxt;
         port0_crossbar_skip_r <= p0_skip_nxt;
         p0_match_r <= p0_match_nxt;
         p0_mask_r <= p0_mask_nxt;
         p1_match_r <= p1_match_nxt;
         p1_mask_r <= p1_mask_nxt;
      end
   end

   // ----------------------------------------
   // Readback
   // ----------------------------------------
   logic [7:0] rdata_nxt;

   always_comb begin
      rdata_nxt = sfr_rdata_r;
      if (sfr_req.rd) begin
         rdata_nxt = gpm_pkg::RST_ZERO;
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_DATA, 1'b1, gpm_pkg::PAGE_0)) begin
            // Read-modify-write sees the latch, plain reads see pins
            rdata_nxt = sfr_req.rmw ? p0_latch_r : p0_digital;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_MATCH, 1'b0, gpm_pkg::PAGE_0)) begin
            rdata_nxt = p0_match_r;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_MASK, 1'b0, gpm_pkg::PAGE_0)) begin
            rdata_nxt = p0_mask_r;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P1_MATCH, 1'b0, gpm_pkg::PAGE_0)) begin
            rdata_nxt = p1_match_r;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P1_MASK, 1'b0, gpm_pkg::PAGE_0)) begin
            rdata_nxt = p1_mask_r;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_IMODE, 1'b0, gpm_pkg::PAGE_F)) begin
            rdata_nxt = p0_imode_r;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_OMODE, 1'b0, gpm_pkg::PAGE_F)) begin
            rdata_nxt = p0_omode_r;
         end
         if (gpm_pkg::gpm_sel(sfr_req, gpm_pkg::ADDR_P0_SKIP, 1'b0, gpm_pkg::PAGE_F)) begin
            rdata_nxt = port0_crossbar_skip_r;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         sfr_rdata_r <= gpm_pkg::RST_ZERO;
      end else begin
         sfr_rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------
   // Pad drive
   // ----------------------------------------
   gpm_pkg::gpm_pad_t pad_nxt;
   logic drv;

   always_comb begin
      pad_nxt = '0;
      drv = 1'b0;
      for (int i = 0; i < WIDTH; i++) begin
         // Crossbar peripherals take the pin, latch otherwise
         drv = xbar_sel[i] ? xbar_dout[i] : p0_latch_r[i];
         if (!p0_imode_r[i]) begin
            pad_nxt.oe_n[i] = 1'b1;
            pad_nxt.analog[i] = 1'b1;
         end else if (p0_omode_r[i] && !smbus_pins[i]) begin
            pad_nxt.out[i] = drv;
            pad_nxt.pullup_en[i] = 1'b1;
         end else begin
            // Open-drain only pulls low
            pad_nxt.oe_n[i] = drv;
            pad_nxt.pullup_en[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pad_r.out <= gpm_pkg::RST_ZERO;
         pad_r.oe_n <= gpm_pkg::RST_DATA;
         pad_r.pullup_en <= gpm_pkg::RST_ZERO;
         pad_r.analog <= gpm_pkg::RST_ZERO;
      end else begin
         pad_r <= pad_nxt;
      end
   end

   // ----------------------------------------
   // Port match event
   // ----------------------------------------
   logic mis_nxt;

   always_comb begin
      mis_nxt = gpm_pkg::gpm_mismatch(p0_digital, p0_match_r, p0_mask_r)
              | gpm_pkg::gpm_mismatch(p1_sync_r, p1_match_r, p1_mask_r);
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         port_mismatch_r <= 1'b0;
         port_wake_r <= 1'b0;
      end else begin
         port_mismatch_r <= mis_nxt;
         port_wake_r <= mis_nxt;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_mismatch_cause: assert property (
      ##1 port_mismatch_r == $past(
         ((p0_sync_r & p0_imode_r & p0_mask_r) != (p0_match_r & p0_mask_r))
         || ((p1_sync_r & p1_mask_r) != (p1_match_r & p1_mask_r))))
      else $error("mismatch flag disagrees with compare");
   a_masked_quiet: assert property (
      (p0_mask_r == 8'h00 && p1_mask_r == 8'h00)[*2] |-> !port_mismatch_r)
      else $error("mismatch with all pins masked off");
   a_wake_follow: assert property (
      port_wake_r == port_mismatch_r)
      else $error("wake and mismatch differ");
   a_latch_hold: assert property (
      !sfr_req.wr |=> $stable(p0_latch_r))
      else $error("latch changed without write");
   a_bit_write: assert property (
      sfr_req.wr && sfr_req.bit_op && sfr_req.addr == gpm_pkg::ADDR_P0_DATA
      |=> p0_latch_r[$past(sfr_req.bit_idx)] == $past(sfr_req.bit_val))
      else $error("bit write not taken");
   a_read_pins: assert property (
      sfr_req.rd && !sfr_req.rmw && sfr_req.addr == gpm_pkg::ADDR_P0_DATA
      |=> sfr_rdata_r == $past(p0_digital))
      else $error("plain read not from pins");
   a_read_latch: assert property (
      sfr_req.rd && sfr_req.rmw && sfr_req.addr == gpm_pkg::ADDR_P0_DATA
      |=> sfr_rdata_r == $past(p0_latch_r))
      else $error("rmw read not from latch");
   // Per pin, so a mixed analog and digital port is checked too
   a_analog_off: assert property (
      ##1 ((pad_r.analog == ~$past(p0_imode_r))
      && ((pad_r.analog & (~pad_r.oe_n | pad_r.pullup_en)) == gpm_pkg::RST_ZERO)))
      else $error("analog pin still digital");
   a_smbus_od: assert property (
      ##1 ((~pad_r.oe_n & pad_r.out & $past(smbus_pins)) == 8'h00))
      else $error("serial bus pin driven high");
   a_page_guard: assert property (
      sfr_req.wr && sfr_req.addr == gpm_pkg::ADDR_P0_MATCH && sfr_req.page != gpm_pkg::PAGE_0
      |=> $stable(p0_match_r))
      else $error("match written off page 0");
   a_skip_write: assert property (
      sfr_req.wr && !sfr_req.bit_op && sfr_req.page == gpm_pkg::PAGE_F
      && sfr_req.addr == gpm_pkg::ADDR_P0_SKIP |=> port0_crossbar_skip_r == $past(sfr_req.wdata))
      else $error("skip write lost");

   c_mismatch_rise: cover property ($rose(port_mismatch_r));
   c_bit_write: cover property (sfr_req.wr && sfr_req.bit_op);
   c_rmw_read: cover property (sfr_req.rd && sfr_req.rmw);
   c_smbus_low: cover property ((smbus_pins & ~pad_r.oe_n) != 8'h00);

endmodule : gpm_port_io
`default_nettype wire

// ---- test_port_io_match_and_mode.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         bad_count++; \
         $display("BAD %s expected %h seen %h", nm, exp, got); \
      end \
   end
module test_port_io_match_and_mode;
   logic clk_sys;
   logic resetn;
   gpm_pkg::gpm_sfr_req_t req;
   logic [7:0] rdata;
   logic [7:0] p0_pin;
   logic [7:0] p1_pin;
   logic [7:0] xbar_sel;
   logic [7:0] xbar_dout;
   logic [7:0] smbus_pins;
   gpm_pkg::gpm_pad_t pad;
   logic [7:0] skip;
   logic mism;
   logic wake;
   logic [7:0] ext_en;
   logic [7:0] ext_val;
   int bad_count = 0;
   int n_compared = 0;
   int cyc = 0;

   gpm_port_io dut_u (.clk_sys(clk_sys), .resetn(resetn), .sfr_req(req), .sfr_rdata_r(rdata),
      .port0_pin_in(p0_pin), .port1_pin_in(p1_pin), .xbar_sel(xbar_sel),
      .xbar_dout(xbar_dout), .smbus_pins(smbus_pins), .pad_r(pad),
      .port0_crossbar_skip_r(skip), .port_mismatch_r(mism), .port_wake_r(wake));

   gpm_pin_model pins_u (.clk_sys(clk_sys), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
      .pin_level(p0_pin));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // ----------
   // Bus cycles
   // ----------
   task automatic acc(input logic w, input logic rmw, input logic bo, input logic [2:0] bi,
                      input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      req <= '{w, !w, rmw, bo, bi, d[0], pg, a, d};
      @(posedge clk_sys);
      req.wr <= 1'b0;
      req.rd <= 1'b0;
   endtask : acc

   task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, 1'b0, 1'b0, 3'h0, pg, a, d);
   endtask : wr

   task automatic rd(input logic [3:0] pg, input logic [7:0] a, input logic rmw);
      acc(1'b0, rmw, 1'b0, 3'h0, pg, a, 8'h00);
      #1;
   endtask : rd

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : settle

   // ---------
   // Scenarios
   // ---------
   task automatic t_reset();
      logic [7:0] ad [8];
      logic [3:0] pg [8];
      logic [7:0] rv [8];
      ad = '{gpm_pkg::ADDR_P0_DATA, gpm_pkg::ADDR_P0_OMODE, gpm_pkg::ADDR_P0_SKIP,
             gpm_pkg::ADDR_P1_MATCH, gpm_pkg::ADDR_P1_MASK, gpm_pkg::ADDR_P0_IMODE,
             gpm_pkg::ADDR_P0_MATCH, gpm_pkg::ADDR_P0_MASK};
      pg = '{4'h0, 4'hF, 4'hF, 4'h0, 4'h0, 4'hF, 4'h0, 4'h0};
      rv = '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00};
      for (int i = 0; i < 8; i++) begin
         rd(pg[i], ad[i], 1'b1);
         `CHK("reset value", rv[i], rdata)
         rd(~pg[i], ad[i], 1'b0);
         `CHK("other page", (i == 0) ? 8'hFF : 8'h00, rdata)
      end
      rd(4'h0, 8'h81, 1'b0);
      `CHK("unmapped", 8'h00, rdata)
      `CHK("skip out", 8'h00, skip)
   endtask : t_reset

   task automatic t_latch();
      wr(4'hF, gpm_pkg::ADDR_P0_OMODE, 8'hFF);
      wr(4'h0, gpm_pkg::ADDR_P0_DATA, 8'h5A);
      settle(2);
      `CHK("pp out", 8'h5A, pad.out)
      `CHK("pp oe_n", 8'h00, pad.oe_n)
      acc(1'b1, 1'b0, 1'b1, 3'h0, 4'h3, gpm_pkg::ADDR_P0_DATA, 8'h01);
      settle(2);
      `CHK("bit write", 8'h5B, pad.out)
      rd(4'h0, gpm_pkg::ADDR_P0_DATA, 1'b0);
      `CHK("pin read", 8'h5B, rdata)
   endtask : t_latch

   task automatic t_openread();
      wr(4'hF, gpm_pkg::ADDR_P0_OMODE, 8'h00);
      wr(4'h0, gpm_pkg::ADDR_P0_DATA, 8'hFF);
      @(posedge clk_sys);
      ext_en <= 8'hFF;
      ext_val <= 8'hF0;
      xbar_sel <= 8'h01;
      xbar_dout <= 8'h00;
      settle(2);
      `CHK("xbar oe_n", 8'hFE, pad.oe_n)
      rd(4'h0, gpm_pkg::ADDR_P0_DATA, 1'b0);
      `CHK("live pins", 8'hF0, rdata)
      rd(4'h0, gpm_pkg::ADDR_P0_DATA, 1'b1);
      `CHK("rmw latch", 8'hFF, rdata)
      @(posedge clk_sys);
      ext_en <= 8'h00;
      xbar_sel <= 8'h00;
   endtask : t_openread

   task automatic t_modes();
      wr(4'hF, gpm_pkg::ADDR_P0_OMODE, 8'hFF);
      @(posedge clk_sys);
      smbus_pins <= 8'h80;
      settle(2);
      `CHK("smbus oe_n", 8'h80, pad.oe_n)
      `CHK("smbus out", 8'h7F, pad.out)
      @(posedge clk_sys);
      smbus_pins <= 8'h00;
      wr(4'hF, gpm_pkg::ADDR_P0_IMODE, 8'hF0);
      settle(2);
      `CHK("analog", 8'h0F, pad.analog)
      `CHK("pullup", 8'hF0, pad.pullup_en)
      `CHK("analog oe_n", 8'h0F, pad.oe_n)
      rd(4'h0, gpm_pkg::ADDR_P0_DATA, 1'b0);
      `CHK("analog read", 8'hF0, rdata)
      wr(4'hF, gpm_pkg::ADDR_P0_IMODE, 8'hFF);
      wr(4'hF, gpm_pkg::ADDR_P0_OMODE, 8'h00);
      wr(4'hF, gpm_pkg::ADDR_P0_SKIP, 8'hA5);
      wr(4'h0, gpm_pkg::ADDR_P0_SKIP, 8'h5A);
      settle(1);
      `CHK("skip out", 8'hA5, skip)
      rd(4'hF, gpm_pkg::ADDR_P0_SKIP, 1'b0);
      `CHK("skip read", 8'hA5, rdata)
   endtask : t_modes

   task automatic t_match();
      wr(4'h0, gpm_pkg::ADDR_P0_MASK, 8'h01);
      settle(1);
      `CHK("match idle", 1'b0, mism)
      @(posedge clk_sys);
      ext_en <= 8'h01;
      ext_val <= 8'h00;
      settle(2);
      `CHK("sync delay", 1'b0, mism)
      settle(1);
      `CHK("mismatch", 1'b1, mism)
      `CHK("wake", 1'b1, wake)
      wr(4'h0, gpm_pkg::ADDR_P0_MATCH, 8'hFE);
      settle(1);
      `CHK("low expected", 1'b0, mism)
      wr(4'h0, gpm_pkg::ADDR_P0_MATCH, 8'hFF);
      wr(4'h0, gpm_pkg::ADDR_P0_MASK, 8'h00);
      settle(1);
      `CHK("masked off", 1'b0, mism)
      wr(4'hF, gpm_pkg::ADDR_P0_MATCH, 8'h00);
      rd(4'h0, gpm_pkg::ADDR_P0_MATCH, 1'b0);
      `CHK("match page", 8'hFF, rdata)
      wr(4'h0, gpm_pkg::ADDR_P1_MASK, 8'h80);
      wr(4'h0, gpm_pkg::ADDR_P1_MATCH, 8'h7F);
      settle(1);
      `CHK("p1 mismatch", 1'b1, mism)
      @(posedge clk_sys);
      p1_pin <= 8'h00;
      settle(3);
      `CHK("p1 unmasked", 1'b0, mism)
   endtask : t_match

   task automatic tally_and_finish();
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      resetn = 1'b0;
      req = '0;
      p1_pin = 8'hFF;
      xbar_sel = 8'h00;
      xbar_dout = 8'h00;
      smbus_pins = 8'h00;
      ext_en = 8'h00;
      ext_val = 8'h00;
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_latch();
      t_openread();
      t_modes();
      t_match();
      tally_and_finish();
   end
endmodule : test_port_io_match_and_mode
`default_nettype wire
